// >>> rtl/nvh_consts.svh
// Timing constants and pin widths for the nonvolatile memory/clock host controller
`ifndef NVH_CONSTS_SVH
`define NVH_CONSTS_SVH
`define NVH_ADDR_W        20
`define NVH_DATA_W        8
`define NVH_RTC_ADDR_W    4
`define NVH_CLK_MHZ       100
`define NVH_ACC_NS        100
`define NVH_ACC_CYC       ((`NVH_ACC_NS*`NVH_CLK_MHZ+999)/1000)
`define NVH_WP_NS         75
`define NVH_WP_CYC        ((`NVH_WP_NS*`NVH_CLK_MHZ+999)/1000)
`define NVH_DS_NS         40
`define NVH_DS_CYC        ((`NVH_DS_NS*`NVH_CLK_MHZ+999)/1000)
`define NVH_WR_NS         20
`define NVH_WR_CYC        ((`NVH_WR_NS*`NVH_CLK_MHZ+999)/1000)
`define NVH_REC_MS        125
`define NVH_REC_CYC       (`NVH_REC_MS*`NVH_CLK_MHZ*1000)
`define NVH_CNT_W         24
`endif

// >>> rtl/nvh_pkg.sv
// Types shared by the host controller files
`default_nettype none
package nvh_pkg;
    typedef struct packed {
        logic        write;   // One for write, zero for read
        logic        rtc;     // One targets clock registers
        logic [19:0] addr;    // Byte address
        logic [7:0]  wdata;   // Write data
    } nvh_req_t;
    typedef struct packed {
        logic ce_n;           // Memory enable
        logic cs_n;           // Clock select
        logic we_n;           // Write strobe
        logic oe_n;           // Output enable
    } nvh_strobe_t;
endpackage
`default_nettype wire

// >>> rtl/nvh_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module nvh_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;  // Metastability stage, read only by s2
    logic [W-1:0] s2;  // Second stage
    logic [W-1:0] s3;  // Third stage
    // Shift chain; output changes only once two settled stages agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule // nvh_sync
`default_nettype wire

// >>> rtl/nvh_host.sv
// Host-side bus controller driving the nonvolatile memory/clock module pins
`timescale 1ns/1ps
`default_nettype none
`include "nvh_consts.svh"
module nvh_host #(
    parameter int unsigned REC_CYC = `NVH_REC_CYC,  // Protection release wait after power good
    parameter int unsigned ACC_CYC = `NVH_ACC_CYC   // Read access wait
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          req_valid,
    input  wire nvh_pkg::nvh_req_t             req,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [`NVH_DATA_W-1:0]             rsp_rdata,
    output logic                               busy,
    input  wire logic                          power_good,
    output logic [`NVH_ADDR_W-1:0]             pin_addr,
    output nvh_pkg::nvh_strobe_t               pin_strobe,
    output logic [`NVH_DATA_W-1:0]             pin_dq_out,
    output logic                               pin_dq_oe,
    input  wire logic [`NVH_DATA_W-1:0]        pin_dq_in
);
    localparam int unsigned WP_CYC = `NVH_WP_CYC;   // Write pulse width
    localparam int unsigned DS_CYC = `NVH_DS_CYC;   // Data setup before pulse end
    localparam int unsigned WR_CYC = `NVH_WR_CYC;   // Recovery after strobe rise

    typedef enum logic [2:0] {
        NVH_PROT, NVH_IDLE, NVH_RSETUP, NVH_RWAIT, NVH_WDATA, NVH_WPULSE, NVH_RECOV
    } nvh_state_t;

    // Phases that pull the target enable low; shared by the pin decode and the phase decode
    function automatic logic in_access(input nvh_state_t s);
        return (s == NVH_RSETUP) || (s == NVH_RWAIT) || (s == NVH_WDATA) || (s == NVH_WPULSE);
    endfunction

    nvh_state_t                state;       // Sequencer state
    nvh_state_t                next_state;  // Next state
    logic [`NVH_CNT_W-1:0]     cnt;         // Phase counter
    logic [`NVH_CNT_W-1:0]     next_cnt;    // Next counter
    logic [`NVH_CNT_W-1:0]     rec_cnt;     // Power-good settle counter
    logic                      pg_sync;     // Synchronised power good
    logic [`NVH_DATA_W-1:0]    dq_sync;     // Synchronised read data
    logic                      cur_write;   // Latched direction
    logic                      cur_rtc;     // Latched target
    logic                      unlocked;    // Protection window over
    logic                      take;        // Request accepted this cycle
    logic                      cnt_done;    // Counter expired
    logic                      sel_n;       // Selected enable for the target
    logic                      next_active; // Next phase pulls a target enable low
    logic                      tgt_rtc;     // Target of the access in flight

    // Pins arrive asynchronously, so both pass the filtered chain
    nvh_sync #(.W(1)) u_pg (
        .clk    (clk),
        .resetn (resetn),
        .din    (power_good),
        .dout   (pg_sync)
    );
    nvh_sync #(.W(`NVH_DATA_W)) u_dq (
        .clk    (clk),
        .resetn (resetn),
        .din    (pin_dq_in),
        .dout   (dq_sync)
    );

    // Power loss wipes the settle count; writes wait the full window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rec_cnt <= '0;
        end else if (!pg_sync) begin
            rec_cnt <= '0;
        end else if (rec_cnt < REC_CYC[`NVH_CNT_W-1:0]) begin
            rec_cnt <= rec_cnt + 1'b1;
        end
    end

    assign unlocked  = pg_sync && (rec_cnt >= REC_CYC[`NVH_CNT_W-1:0]);
    assign take      = (state == NVH_IDLE) && req_valid && unlocked;
    assign cnt_done  = (cnt == '0);

    // Sequencer: every access ends in a recovery phase with strobes high
    always_comb begin
        next_state = state;
        next_cnt   = (cnt == '0) ? cnt : cnt - 1'b1;
        unique case (state)
            NVH_PROT: begin
                if (unlocked) begin
                    next_state = NVH_IDLE;
                end
            end
            NVH_IDLE: begin
                if (!unlocked) begin
                    next_state = NVH_PROT;
                end else if (take) begin
                    next_state = req.write ? NVH_WDATA : NVH_RSETUP;
                    next_cnt   = '0;
                end
            end
            NVH_RSETUP: begin
                next_state = NVH_RWAIT;
                next_cnt   = ACC_CYC[`NVH_CNT_W-1:0];
            end
            NVH_RWAIT: begin
                if (cnt_done) begin
                    next_state = NVH_RECOV;
                    next_cnt   = WR_CYC[`NVH_CNT_W-1:0];
                end
            end
            NVH_WDATA: begin
                next_state = NVH_WPULSE;
                next_cnt   = (WP_CYC > DS_CYC ? WP_CYC[`NVH_CNT_W-1:0] : DS_CYC[`NVH_CNT_W-1:0]) - 1'b1;
            end
            NVH_WPULSE: begin
                // Power failing mid-pulse ends the write at once
                if (cnt_done || !pg_sync) begin
                    next_state = NVH_RECOV;
                    next_cnt   = WR_CYC[`NVH_CNT_W-1:0];
                end
            end
            NVH_RECOV: begin
                if (cnt_done) begin
                    next_state = unlocked ? NVH_IDLE : NVH_PROT;
                end
            end
        endcase
    end

    // Target enable low only in active phases; the other one stays high
    assign sel_n       = !in_access(state);
    // Pins are registered, so they are decoded from the phase about to start
    assign next_active = in_access(next_state);
    assign tgt_rtc     = take ? req.rtc : cur_rtc;

    // State, latched request and pin registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= NVH_PROT;
            cnt       <= '0;
            cur_write <= 1'b0;
            cur_rtc   <= 1'b0;
            pin_addr  <= '0;
            pin_dq_out <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (take) begin
                cur_write  <= req.write;
                cur_rtc    <= req.rtc;
                // Clock registers use only the low four address lines
                pin_addr   <= req.rtc ? {{(`NVH_ADDR_W-`NVH_RTC_ADDR_W){1'b0}}, req.addr[`NVH_RTC_ADDR_W-1:0]}
                                      : req.addr;
                pin_dq_out <= req.wdata;
            end
        end
    end

    // Pin strobes come from flops; computed one cycle ahead from next_state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_strobe <= '{ce_n: 1'b1, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
            pin_dq_oe  <= 1'b0;
        end else begin
            // Memory target uses enable, clock target uses select
            pin_strobe.ce_n <= next_active ? tgt_rtc : 1'b1;
            pin_strobe.cs_n <= next_active ? !tgt_rtc : 1'b1;
            // Strobe low only during the pulse, gated by power good
            pin_strobe.we_n <= !(next_state == NVH_WPULSE && pg_sync);
            // Output enable only in reads; writes keep it high
            pin_strobe.oe_n <= !(next_state == NVH_RWAIT);
            // Drive the bus only while writing, so device drivers stay off
            pin_dq_oe <= (next_state == NVH_WDATA) || (next_state == NVH_WPULSE);
        end
    end

    // Response and status flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            req_ready <= 1'b0;
            busy      <= 1'b0;
        end else begin
            // Sample once access time has passed
            rsp_valid <= (state == NVH_RWAIT && cnt_done) || (state == NVH_WPULSE && next_state == NVH_RECOV);
            if (state == NVH_RWAIT && cnt_done) begin
                rsp_rdata <= dq_sync;
            end
            req_ready <= (next_state == NVH_IDLE) && unlocked && !take;
            busy      <= (next_state != NVH_IDLE);
        end
    end

    // Both enables low together is forbidden
    a_no_invalid_mode: assert property (@(posedge clk) disable iff (!resetn)
        !(!pin_strobe.ce_n && !pin_strobe.cs_n)) else $error("enable and select low together");
    // No write strobe the cycle after synchronised power good is low
    a_write_blocked: assert property (@(posedge clk) disable iff (!resetn)
        !pg_sync |=> pin_strobe.we_n) else $error("write strobe during power fail");
    // Reads keep strobe high
    a_read_we_high: assert property (@(posedge clk) disable iff (!resetn)
        !pin_strobe.oe_n |-> pin_strobe.we_n) else $error("strobe low in read");
    // Output enable high whenever host drives
    a_no_contention: assert property (@(posedge clk) disable iff (!resetn)
        pin_dq_oe |-> pin_strobe.oe_n) else $error("bus contention");
    // Write strobe high on the cycle it rises and on the cycle after
    a_recovery_gap: assert property (@(posedge clk) disable iff (!resetn)
        $rose(pin_strobe.we_n) |-> pin_strobe.we_n[*2]) else $error("recovery too short");
    // Address stable through the pulse
    a_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
        (!pin_strobe.we_n && !$past(pin_strobe.we_n)) |-> $stable(pin_addr)) else $error("address moved");
    // Strobe only inside a select window
    a_pulse_overlap: assert property (@(posedge clk) disable iff (!resetn)
        !pin_strobe.we_n |-> (!pin_strobe.ce_n || !pin_strobe.cs_n) && pin_dq_oe) else $error("bad pulse");
    // Clock targets use only low address lines
    a_rtc_addr: assert property (@(posedge clk) disable iff (!resetn)
        !pin_strobe.cs_n |-> pin_addr[`NVH_ADDR_W-1:`NVH_RTC_ADDR_W] == '0) else $error("rtc address wide");
    // Decoded phase and registered enables always agree
    a_select_phase: assert property (@(posedge clk) disable iff (!resetn)
        sel_n == (pin_strobe.ce_n && pin_strobe.cs_n)) else $error("enable outside access");
    // Write strobe only inside a latched write
    a_write_dir: assert property (@(posedge clk) disable iff (!resetn)
        !pin_strobe.we_n |-> cur_write) else $error("strobe low in read access");
endmodule // nvh_host
`default_nettype wire

// >>> verification/nvh_dev_model.sv
// Behavioural model of the battery-backed memory and calendar clock module
`timescale 1ns/1ps
`default_nettype none
module nvh_dev_model #(
    parameter int unsigned LAT = 2  // Cycles from settled address and oe_n to valid data
) (
    input  wire logic                 clk,
    input  wire logic                 power_good,
    input  wire logic [19:0]          addr,
    input  wire nvh_pkg::nvh_strobe_t stb,
    input  wire logic [7:0]           bus,
    output logic      [7:0]           dq
);
    logic [7:0]  mem [1048576];                 // Every one of the 20 lines decoded
    // Calendar bytes kept as written; counting and the hidden copy are invisible to the host
    logic [7:0]  rtc [16] = '{default: 8'h00};  // Flags clear, battery healthy
    logic [7:0]  wbuf;                          // Data seen during the write pulse
    logic [19:0] wadr;                          // Address of the pending write
    logic        wrtc;                          // Pending write targets clock registers
    logic        wact      = 1'b0;              // Write waits for the pulse to close
    logic [19:0] last_addr;                     // Address one cycle ago
    int unsigned age       = 0;                 // Cycles since address and oe_n settled
    wire mem_rd = !stb.ce_n && stb.cs_n && stb.we_n;
    wire rtc_rd = stb.ce_n && !stb.cs_n && stb.we_n;
    // Invalid mode has both selects low, so it never counts as a pulse
    wire pulse  = !stb.we_n && (stb.ce_n != stb.cs_n);
    // Standby, writes and oe_n high float the bus
    wire drive  = power_good && !stb.oe_n && (mem_rd || rtc_rd) && age >= LAT;
    wire [7:0] rd = mem_rd ? mem[addr] : rtc[addr[3:0]];
    initial dq = 8'h00;
    // Data is committed only when the overlap ends with supply still good
    always @(posedge clk) begin
        age <= (addr != last_addr || stb.oe_n) ? 0 : age + 1;
        last_addr <= addr;
        if (!power_good) begin
            wact <= 1'b0;               // Out of tolerance: write dropped
        end else if (pulse) begin
            wact <= 1'b1;
            wbuf <= bus;
            wadr <= addr;
            wrtc <= !stb.cs_n;
        end else if (wact && wrtc) begin
            rtc[wadr[3:0]] <= wbuf;
            wact <= 1'b0;
        end else if (wact) begin
            mem[wadr] <= wbuf;
            wact <= 1'b0;
        end
        // A released bus toggles, so the host's agreement filter holds the last byte that settled
        dq <= drive ? rd : ~dq;
    end
endmodule // nvh_dev_model
`default_nettype wire

// >>> verification/test_nvh_host.sv
// Self-checking bench for the host controller against the module model
`timescale 1ns/1ps
`default_nettype none
`include "nvh_consts.svh"
module test_nvh_host;
    localparam int unsigned REC = 20;     // Shortened protection release wait
    logic                 clk        = 1'b0;
    logic                 resetn     = 1'b0;
    logic                 req_valid  = 1'b0;
    logic                 power_good = 1'b1;
    nvh_pkg::nvh_req_t    req        = '0;
    logic                 req_ready, rsp_valid, busy, pin_dq_oe;
    logic [7:0]           rsp_rdata, pin_dq_out, dev_dq, bus;
    logic [19:0]          pin_addr;
    nvh_pkg::nvh_strobe_t pin_strobe;
    logic [19:0]          wr_addr;        // Address on the previous cycle
    int unsigned          low_cnt    = 0; // Cycles the write strobe has been low
    int                   mismatches = 0;
    int                   n_tests    = 0;
    always #5 clk = ~clk;
    // Host drives only with its enable up; otherwise the module owns the bus
    assign bus = pin_dq_oe ? pin_dq_out : dev_dq;
    nvh_host #(.REC_CYC(REC), .ACC_CYC(10)) i_dut (
        .clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .power_good(power_good),
        .pin_addr(pin_addr), .pin_strobe(pin_strobe), .pin_dq_out(pin_dq_out),
        .pin_dq_oe(pin_dq_oe), .pin_dq_in(bus));
    nvh_dev_model #(.LAT(2)) i_dev (
        .clk(clk), .power_good(power_good), .addr(pin_addr), .stb(pin_strobe), .bus(bus), .dq(dev_dq));
    task automatic tally_and_finish();
        $display("Counts: %0d mismatches in %0d comparisons", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // Bounded wait for ready (rsp low) or response (rsp high), sampled at rising edges
    task automatic wait_hi(input bit rsp);
        int   i;
        logic s;
        i = 0;
        do begin
            @(posedge clk);
            i++;
            s = rsp ? rsp_valid : req_ready;
        end while (s !== 1'b1 && i < 300);
        chk(s, "handshake timed out");
        if (s !== 1'b1) tally_and_finish();
    endtask
    // One whole access; read data is judged against the expected byte
    task automatic access(input logic wr, input logic rt, input logic [19:0] a, input logic [7:0] d,
                          input logic [7:0] exp);
        req <= '{write: wr, rtc: rt, addr: a, wdata: d};
        req_valid <= 1'b1;
        wait_hi(1'b0);
        req_valid <= 1'b0;
        wait_hi(1'b1);
        chk(busy === 1'b1 && req_ready === 1'b0, "idle before recovery");
        if (!wr) chk(rsp_rdata === exp, "read data");
    endtask
    // Holds a request up while the controller must stay locked; the next access replaces it
    task automatic refused(input int n);
        req_valid <= 1'b1;
        repeat (n) begin
            @(posedge clk);
            chk(req_ready === 1'b0 && (pin_strobe.ce_n & pin_strobe.cs_n) === 1'b1, "taken while locked");
        end
    endtask
    // Boundary addresses written back to back, read back in reverse
    task automatic run_mem();
        logic [19:0] a [3] = '{20'h00000, 20'hfffff, 20'h80001};
        logic [7:0]  d [3] = '{8'hc3, 8'h3c, 8'h96};
        for (int k = 0; k < 3; k++) access(1'b1, 1'b0, a[k], d[k], 8'h00);
        for (int k = 2; k >= 0; k--) access(1'b0, 1'b0, a[k], 8'h00, d[k]);
    endtask
    // Clock registers use the low four lines and a space apart from memory
    task automatic run_rtc();
        access(1'b1, 1'b1, 20'hfff3, 8'h47, 8'h00);
        access(1'b1, 1'b0, 20'h00003, 8'h11, 8'h00);
        access(1'b0, 1'b1, 20'h00003, 8'h00, 8'h47);
        access(1'b0, 1'b0, 20'h00003, 8'h00, 8'h11);
    endtask
    // Supply lost in mid-write: pulse cut, old byte kept, lock on return
    task automatic run_power();
        access(1'b1, 1'b0, 20'h2aaaa, 8'h5a, 8'h00);
        req <= '{write: 1'b1, rtc: 1'b0, addr: 20'h2aaaa, wdata: 8'ha5};
        req_valid <= 1'b1;
        wait_hi(1'b0);
        req_valid <= 1'b0;
        @(posedge clk);
        power_good <= 1'b0;
        // Drop lands early enough that the cut comes well before the full pulse width
        repeat (6) @(posedge clk);
        chk(pin_strobe.we_n === 1'b1, "write pulse not cut");
        repeat (2) @(posedge clk);
        chk(pin_strobe.we_n && pin_strobe.ce_n && pin_strobe.cs_n, "strobes active without power");
        refused(8);
        power_good <= 1'b1;
        refused(REC - 6);
        access(1'b0, 1'b0, 20'h2aaaa, 8'h00, 8'h5a);
    endtask
    // Pin monitor for strobe combinations and write timing
    always @(posedge clk) begin
        if (resetn) begin
            chk(pin_strobe.ce_n || pin_strobe.cs_n, "both selects low");
            chk(!(pin_dq_oe && !pin_strobe.oe_n), "bus contention");
            chk(pin_strobe.oe_n || pin_strobe.we_n, "write strobe low while reading");
            if (!pin_strobe.we_n) chk(pin_strobe.ce_n != pin_strobe.cs_n, "bad select");
            if (!pin_strobe.we_n && low_cnt != 0) chk(pin_addr === wr_addr, "address moved");
            if (pin_strobe.we_n && low_cnt != 0 && power_good) chk(low_cnt >= `NVH_WP_CYC, "short pulse");
        end
        low_cnt <= pin_strobe.we_n ? 0 : low_cnt + 1;
        wr_addr <= pin_addr;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        req <= '{write: 1'b1, rtc: 1'b0, addr: 20'h00003, wdata: 8'h11};
        refused(REC - 6);
        run_mem();
        run_rtc();
        run_power();
        tally_and_finish();
    end
endmodule // test_nvh_host
`default_nettype wire
